// ==== rtl/ecsl_params.svh ====
`ifndef ECSL_PARAMS_SVH
`define ECSL_PARAMS_SVH
// Status byte bit positions
`define ECSL_SB_ZERO_VALID 0
`define ECSL_SB_EXT_VALID 1
`define ECSL_SB_PRESET_ACC 2
`define ECSL_SB_UNDERFLOW 3
`define ECSL_SB_OVERFLOW 4
`define ECSL_SB_INPUT 5
`define ECSL_SB_RESET 8'h00
// Control byte bit positions
`define ECSL_CB_ARM_ZERO 0
`define ECSL_CB_ARM_RISE 1
`define ECSL_CB_LOAD_PRESET 2
`define ECSL_CB_ARM_FALL 3
// Hysteresis thresholds of the 16-bit counter
`define ECSL_CNT_MAX 16'hffff
`define ECSL_OVF_CLR_FROM 16'h5555
`define ECSL_OVF_CLR_TO 16'h5556
`define ECSL_UNF_CLR_FROM 16'haaaa
`define ECSL_UNF_CLR_TO 16'haaa9
// Operating modes
`define ECSL_MODE_FREE_32 4'h7
`define ECSL_MODE_FREE_16 4'h8
`define ECSL_MODE_DC_32 4'h9
`define ECSL_MODE_DC_16 4'ha
// Default local cycle interval: 1000 us at 50 MHz
`define ECSL_CYCLE_US 1000
`define ECSL_CLK_MHZ 50
`define ECSL_CYCLE_CYCLES (`ECSL_CYCLE_US * `ECSL_CLK_MHZ)
`endif

// ==== rtl/ecsl_pkg.sv ====
package ecsl_pkg;
   typedef enum logic [1:0] {
      ECSL_SYNC_FRAME = 2'b00,
      ECSL_SYNC_CLOCK = 2'b01,
      ECSL_SYNC_INPUT = 2'b10
   } ecsl_sync_t;
endpackage : ecsl_pkg

// ==== rtl/ecsl_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output changes once stages two and three agree
module ecsl_pin_sync (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic pin,
   output logic level
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         level <= 1'b0;
      end else if (s2 == s3) begin
         level <= s3;
      end
   end
endmodule : ecsl_pin_sync
`default_nettype wire

// ==== rtl/ecsl_status_latch.sv ====
// Function
// [R01] Set overflow when the 16-bit counter wraps 65535 to 0.
// [R02] Clear overflow on step 21845 to 21846, or at once on underflow.
// [R03] Set underflow when the 16-bit counter wraps 0 to 65535.
// [R04] Clear underflow on step 43690 to 43689, or at once on overflow.
// [R05] Raise preset-accepted once the preset value has been loaded.
// [R06] External latch valid after armed pulse; latch word holds captured count. A later zero capture still overwrites the shared word.
// [R07] Controller clears then sets the external arm bit to re-arm.
// [R08] Zero latch valid after armed index capture; latch word holds count. A later external capture still overwrites the shared word.
// [R09] Controller clears then sets the zero arm bit to re-arm.
// [R10] Copy digital input one level into the input-state status bit.
// [R11] Status byte goes to the controller in the input image.
// [R12] Modes 7 and 9 report 32-bit values; modes 8 and 10 16-bit.
// [R13] Frame-triggered mode starts each cycle on the frame event.
// [R14] Clock-synced mode starts cycles from the local clock at intervals.
// [R15] Input-based mode uses clock cycles aligned to input devices.
// [R16] Single-ended encoders accepted; forward-count option must be false.
// [R17] Rising edge of load_preset loads the counter with the preset.
// [R18] Capture on first matching edge when armed and valid bit low.
// [R19] Zero latch has priority; its valid clears only while index low.
// [R20] Refresh every status flag once per processing cycle as a snapshot.
`timescale 1ns/1ps
`default_nettype none
`include "ecsl_params.svh"
module ecsl_status_latch #(
   parameter int unsigned CYCLE_CYCLES = `ECSL_CYCLE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Counter from the quadrature decoder
   input wire logic count_step,
   input wire logic count_up,
   input wire logic [31:0] count_value,
   output logic preset_load,
   output logic [31:0] preset_value_out,
   // Pins
   input wire logic ext_latch_pin,
   input wire logic zero_index_pin,
   input wire logic digital_input_pin,
   // Output process data from the controller
   input wire logic [7:0] encoder_control_byte,
   input wire logic [31:0] preset_value,
   // Configuration
   input wire logic [3:0] op_mode,
   input wire ecsl_pkg::ecsl_sync_t sync_mode,
   input wire logic forward_count_en,
   input wire logic frame_event,
   input wire logic input_align_event,
   // Input process data to the controller
   output logic [7:0] encoder_status_byte,
   output logic [31:0] count_report,
   output logic [31:0] latch_report,
   output logic cycle_start,
   output logic config_error
);
   logic ext_lvl;
   logic ext_prev;
   logic zero_lvl;
   logic zero_prev;
   logic din_lvl;
   logic load_prev;
   logic arm_zero_prev;
   logic arm_ext_prev;
   logic ext_armed;
   logic zero_armed;
   logic overflow;
   logic underflow;
   logic preset_acc;
   logic ext_valid;
   logic zero_valid;
   logic [31:0] latch_value;
   logic [31:0] cycle_cnt;
   logic clock_tick;
   logic aligned;
   logic [15:0] prev_cnt;
   logic arm_rise;
   logic arm_fall;
   logic arm_zero;
   logic arm_ext;
   logic ext_hit;
   logic zero_hit;
   logic wrap_up;
   logic wrap_dn;

   function automatic logic [31:0] mode_width(input logic [3:0] mode, input logic [31:0] v);
      if (mode == `ECSL_MODE_FREE_16 || mode == `ECSL_MODE_DC_16) begin
         return {16'h0000, v[15:0]};
      end
      return v;
   endfunction : mode_width

   ecsl_pin_sync u_ext (.sys_clk(sys_clk), .rstn(rstn), .pin(ext_latch_pin), .level(ext_lvl));
   ecsl_pin_sync u_zero (.sys_clk(sys_clk), .rstn(rstn), .pin(zero_index_pin), .level(zero_lvl));
   ecsl_pin_sync u_din (.sys_clk(sys_clk), .rstn(rstn), .pin(digital_input_pin), .level(din_lvl));

   assign arm_rise = encoder_control_byte[`ECSL_CB_ARM_RISE];
   assign arm_fall = encoder_control_byte[`ECSL_CB_ARM_FALL];
   assign arm_zero = encoder_control_byte[`ECSL_CB_ARM_ZERO];
   assign arm_ext = arm_rise | arm_fall;
   assign prev_cnt = count_value[15:0];
   // Wrap seen on the step about to be applied to the current value
   assign wrap_up = count_step && count_up && prev_cnt == `ECSL_CNT_MAX;
   assign wrap_dn = count_step && !count_up && prev_cnt == 16'h0000;
   assign zero_hit = zero_armed && !zero_valid && zero_lvl && !zero_prev;
   assign ext_hit = ext_armed && !ext_valid && !zero_hit &&
      ((arm_rise && ext_lvl && !ext_prev) || (arm_fall && !ext_lvl && ext_prev)); // see [R18] [R19]

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_prev <= 1'b0;
         zero_prev <= 1'b0;
         load_prev <= 1'b0;
         arm_zero_prev <= 1'b0;
         arm_ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_lvl;
         zero_prev <= zero_lvl;
         load_prev <= encoder_control_byte[`ECSL_CB_LOAD_PRESET];
         arm_zero_prev <= arm_zero;
         arm_ext_prev <= arm_ext;
      end
   end

   // Hysteresis flags; the opposite wrap clears at once
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         overflow <= 1'b0;
         underflow <= 1'b0;
      end else begin
         if (wrap_up) begin
            overflow <= 1'b1; // see [R01]
         end else if (wrap_dn) begin
            overflow <= 1'b0; // see [R02]
         end else if (count_step && count_up && prev_cnt == `ECSL_OVF_CLR_FROM) begin
            overflow <= 1'b0; // see [R02]
         end
         if (wrap_dn) begin
            underflow <= 1'b1; // see [R03]
         end else if (wrap_up) begin
            underflow <= 1'b0; // see [R04]
         end else if (count_step && !count_up && prev_cnt == `ECSL_UNF_CLR_FROM) begin
            underflow <= 1'b0; // see [R04]
         end
      end
   end

   // Preset load on rising edge; acceptance follows the load
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         preset_load <= 1'b0;
         preset_value_out <= 32'h0000_0000;
         preset_acc <= 1'b0;
      end else begin
         preset_load <= encoder_control_byte[`ECSL_CB_LOAD_PRESET] && !load_prev; // see [R17]
         if (encoder_control_byte[`ECSL_CB_LOAD_PRESET] && !load_prev) begin
            preset_value_out <= preset_value;
         end
         if (preset_load) begin
            preset_acc <= 1'b1; // see [R05]
         end else if (!encoder_control_byte[`ECSL_CB_LOAD_PRESET]) begin
            preset_acc <= 1'b0;
         end
      end
   end

   // Arming needs a fresh rising edge of the enable, so clear-then-set re-arms
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_armed <= 1'b0;
         zero_armed <= 1'b0;
      end else begin
         if (!arm_ext) begin
            ext_armed <= 1'b0;
         end else if (!arm_ext_prev) begin
            ext_armed <= 1'b1; // see [R07]
         end else if (ext_hit) begin
            ext_armed <= 1'b0;
         end
         if (!arm_zero) begin
            zero_armed <= 1'b0;
         end else if (!arm_zero_prev) begin
            zero_armed <= 1'b1; // see [R09]
         end else if (zero_hit) begin
            zero_armed <= 1'b0;
         end
      end
   end

   // Capture; each valid bit blocks only its own source, so the shared word is frozen only while both stand
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ext_valid <= 1'b0;
         zero_valid <= 1'b0;
         latch_value <= 32'h0000_0000;
      end else begin
         if (zero_hit) begin
            zero_valid <= 1'b1; // see [R08]
            latch_value <= count_value;
         end else if (!arm_zero && !zero_lvl) begin
            zero_valid <= 1'b0; // see [R19]
         end
         if (ext_hit) begin
            ext_valid <= 1'b1; // see [R06]
            latch_value <= count_value;
         end else if (!arm_ext) begin
            ext_valid <= 1'b0;
         end
      end
   end

   // Processing cycle source
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cycle_cnt <= 32'h0000_0000;
         clock_tick <= 1'b0;
         aligned <= 1'b0;
      end else begin
         clock_tick <= 1'b0;
         if (cycle_cnt == CYCLE_CYCLES - 1) begin
            cycle_cnt <= 32'h0000_0000;
            clock_tick <= 1'b1; // see [R14]
         end else begin
            cycle_cnt <= cycle_cnt + 32'h0000_0001;
         end
         if (input_align_event) begin
            aligned <= 1'b1;
         end else if (clock_tick) begin
            aligned <= 1'b0;
         end
      end
   end

   always_comb begin
      unique case (sync_mode)
         ecsl_pkg::ECSL_SYNC_FRAME: cycle_start = frame_event; // see [R13]
         ecsl_pkg::ECSL_SYNC_CLOCK: cycle_start = clock_tick; // see [R14]
         ecsl_pkg::ECSL_SYNC_INPUT: cycle_start = clock_tick && aligned; // see [R15]
         default: cycle_start = 1'b0;
      endcase
   end

   // Snapshot of status byte, count, latch and config error at each cycle start
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         encoder_status_byte <= `ECSL_SB_RESET;
         count_report <= 32'h0000_0000;
         latch_report <= 32'h0000_0000;
         config_error <= 1'b0;
      end else if (cycle_start) begin
         encoder_status_byte <= {2'b00, din_lvl, overflow, underflow, preset_acc,
            ext_valid, zero_valid}; // see [R10] [R11] [R20]
         count_report <= mode_width(op_mode, count_value); // see [R12]
         latch_report <= mode_width(op_mode, latch_value); // see [R12]
         config_error <= forward_count_en; // see [R16]
      end
   end
endmodule : ecsl_status_latch
`default_nettype wire

// ==== testbench/ecsl_encoder_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Encoder side: steps on request and takes preset loads from the block
module ecsl_encoder_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Step requests from the bench
   input wire logic step_req,
   input wire logic step_dir,
   // Preset handed over by the block
   input wire logic preset_load,
   input wire logic [31:0] preset_value_out,
   // Counter towards the block
   output logic count_step,
   output logic count_up,
   output logic [31:0] count_value
);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         count_step <= 1'b0;
         count_up <= 1'b0;
         count_value <= 32'h0;
      end else begin
         count_step <= step_req;
         count_up <= step_dir;
         // Count shown during a step is the value before it
         if (preset_load) count_value <= preset_value_out;
         else if (count_step) count_value <= count_value + (count_up ? 32'h1 : 32'hffffffff);
      end
   end
endmodule : ecsl_encoder_model
`default_nettype wire

// ==== testbench/ecsl_status_latch_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecsl_status_latch_sva #(
   parameter int unsigned CYCLE_CYCLES = 8
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Configuration and control
   input wire logic [3:0] op_mode,
   input wire ecsl_pkg::ecsl_sync_t sync_mode,
   input wire logic [7:0] encoder_control_byte,
   // Watched outputs
   input wire logic preset_load,
   input wire logic cycle_start,
   input wire logic [7:0] encoder_status_byte,
   input wire logic [31:0] count_report,
   input wire logic [31:0] latch_report
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   stat_hold_a: assert property (!cycle_start |=> $stable(encoder_status_byte))
      else $error("status moved between cycle starts");
   count_hold_a: assert property (!cycle_start |=> $stable(count_report) && $stable(latch_report))
      else $error("report moved between cycle starts");
   upper_zero_a: assert property (cycle_start && (op_mode == 4'h8 || op_mode == 4'ha) |=> count_report[31:16] == 16'h0)
      else $error("compact count has upper bits");
   reserved_zero_a: assert property (encoder_status_byte[7:6] == 2'b00)
      else $error("reserved status bits set");
   preset_pulse_a: assert property ($rose(encoder_control_byte[2]) |=> preset_load ##1 !preset_load)
      else $error("preset load pulse wrong");
   flag_excl_a: assert property (!(encoder_status_byte[4] && encoder_status_byte[3]))
      else $error("overflow and underflow both set");
   // Valid rises one edge after the snapshot, which is at least one edge after the capture
   ext_armed_a: assert property ($rose(encoder_status_byte[1]) |-> $past(encoder_control_byte[1] | encoder_control_byte[3], 2))
      else $error("external capture while unarmed");
   // Period literal matches the eight-cycle interval set in the bench
   clock_period_a: assert property (sync_mode == ecsl_pkg::ECSL_SYNC_CLOCK && cycle_start |=> (!cycle_start) [*7] ##1 cycle_start)
      else $error("local cycle period wrong");
endmodule : ecsl_status_latch_sva
bind ecsl_status_latch ecsl_status_latch_sva #(.CYCLE_CYCLES(CYCLE_CYCLES)) u_sva (.*);
`default_nettype wire

// ==== testbench/ecsl_status_latch_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ecsl_status_latch_tb;
   // Forward count held off for a single-ended encoder
   logic sys_clk = 1'b0, rstn = 1'b0, step_req = 1'b0, step_dir = 1'b0, forward_count_en = 1'b0;
   logic ext_latch_pin = 1'b0, zero_index_pin = 1'b0, digital_input_pin = 1'b0;
   logic count_step, count_up, preset_load, cycle_start, config_error, frame_event = 1'b0;
   logic frame_on = 1'b1;
   logic [3:0] op_mode = 4'h7;
   logic [2:0] fcnt = 3'h0;
   logic [7:0] encoder_control_byte = 8'h00, encoder_status_byte, esb = 8'h00;
   logic [31:0] preset_value = 32'h0, preset_value_out, count_value, count_report, latch_report;
   logic [31:0] ecnt = 32'h0, elat, nstart;
   // Both at-once clears and both hysteresis clears are reached
   logic [31:0] pre [6] = '{32'hffff, 32'h10000, 32'hffff, 32'h5555, 32'h10000, 32'haaaa};
   logic [5:0] dir = 6'b001101;
   logic [7:0] arm [3] = '{8'h02, 8'h08, 8'h01};
   ecsl_pkg::ecsl_sync_t sync_mode = ecsl_pkg::ECSL_SYNC_FRAME;
   int mismatches = 0, n_compared = 0;
   ecsl_status_latch #(.CYCLE_CYCLES(8)) u_ecsl_status_latch (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .count_step(count_step),
      .count_up(count_up),
      .count_value(count_value),
      .preset_load(preset_load),
      .preset_value_out(preset_value_out),
      .ext_latch_pin(ext_latch_pin),
      .zero_index_pin(zero_index_pin),
      .digital_input_pin(digital_input_pin),
      .encoder_control_byte(encoder_control_byte),
      .preset_value(preset_value),
      .op_mode(op_mode),
      .sync_mode(sync_mode),
      .forward_count_en(forward_count_en),
      .frame_event(frame_event),
      .input_align_event(frame_event),
      .encoder_status_byte(encoder_status_byte),
      .count_report(count_report),
      .latch_report(latch_report),
      .cycle_start(cycle_start),
      .config_error(config_error)
   );
   ecsl_encoder_model u_ecsl_encoder_model (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .step_req(step_req),
      .step_dir(step_dir),
      .preset_load(preset_load),
      .preset_value_out(preset_value_out),
      .count_step(count_step),
      .count_up(count_up),
      .count_value(count_value)
   );
   initial forever #10 sys_clk = ~sys_clk;
   // One frame every eight cycles keeps snapshots coming; frame_on stops them
   always @(posedge sys_clk) fcnt <= fcnt + 3'h1;
   always @(posedge sys_clk) frame_event <= (fcnt == 3'h6) && frame_on;
   function automatic logic [31:0] expect_w(input logic [31:0] v);
      return (op_mode == 4'h7 || op_mode == 4'h9) ? v : v & 32'hffff;
   endfunction : expect_w
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) mismatches++;
      if (seen !== exp) $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : cyc
   // Nearly three frames (23 cycles), so the snapshot lag never matters; looked at mid-cycle, off the update edge
   task automatic check_all;
      cyc(23);
      @(negedge sys_clk);
      check(encoder_status_byte, esb);
      check(count_report, expect_w(ecnt));
      @(posedge sys_clk);
   endtask : check_all
   // Counts cycle starts over forty cycles, sampled mid-cycle
   task automatic count_starts(output logic [31:0] n);
      n = 32'h0;
      repeat (40) begin
         @(negedge sys_clk);
         n = n + {31'h0, cycle_start};
      end
      @(posedge sys_clk);
   endtask : count_starts
   task automatic preset(input logic [31:0] v);
      preset_value <= v;
      encoder_control_byte[2] <= 1'b1;
      cyc(3);
      ecnt = v;
      esb[2] = 1'b1;
      check_all();
      encoder_control_byte[2] <= 1'b0;
      esb[2] = 1'b0;
      // The next preset needs the bit seen low first, or no rising edge appears
      cyc(1);
   endtask : preset
   task automatic step(input logic up);
      esb[5] = 1'($urandom_range(1));
      digital_input_pin <= esb[5];
      step_req <= 1'b1;
      step_dir <= up;
      cyc(1);
      step_req <= 1'b0;
      cyc(1);
      if (up && ecnt[15:0] == 16'hffff) esb[4:3] = 2'b10;
      if (up && ecnt[15:0] == 16'h5555) esb[4] = 1'b0;
      if (!up && ecnt[15:0] == 16'h0) esb[4:3] = 2'b01;
      if (!up && ecnt[15:0] == 16'haaaa) esb[3] = 1'b0;
      ecnt = up ? ecnt + 32'h1 : ecnt - 32'h1;
   endtask : step
   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   initial begin
      void'($urandom(32'h797650ff));
      cyc(4);
      rstn <= 1'b1;
      cyc(1);
      check(encoder_status_byte, 8'h00);
      for (int m = 7; m <= 10; m++) begin
         op_mode <= 4'(m);
         preset(32'h12345678);
      end
      for (int i = 0; i < 6; i++) begin
         preset(pre[i]);
         step(dir[i]);
         check_all();
      end
      $display("counter tests done");
      for (int k = 0; k < 3; k++) begin
         step(1'b1);
         encoder_control_byte <= arm[k];
         cyc(2);
         ext_latch_pin <= (k == 0);
         zero_index_pin <= (k == 2);
         cyc(8);
         zero_index_pin <= 1'b0;
         elat = ecnt;
         esb[k == 2 ? 0 : 1] = 1'b1;
         step(1'b1);
         check_all();
         check(latch_report, expect_w(elat));
         encoder_control_byte <= 8'h00;
         esb[1:0] = 2'b00;
      end
      $display("latch tests done");
      forward_count_en <= 1'b1;
      check_all();
      check(config_error, 1'b1);
      count_starts(nstart);
      check(nstart, 32'h5);
      sync_mode <= ecsl_pkg::ECSL_SYNC_CLOCK;
      count_starts(nstart);
      check(nstart, 32'h5);
      sync_mode <= ecsl_pkg::ECSL_SYNC_INPUT;
      count_starts(nstart);
      check(nstart, 32'h5);
      // Without align events the local ticks alone must not start cycles
      frame_on <= 1'b0;
      cyc(24);
      count_starts(nstart);
      check(nstart, 32'h0);
      $display("config and clock tests done");
      finish_test();
   end
endmodule : ecsl_status_latch_tb
`default_nettype wire
